// ### hdl/eps_status_regs.sv
// ECC result and block protection status registers behind an APB slave
`timescale 1ns/100ps
`default_nettype none
`include "eps_params.svh"

////////////////////////////////////////////////////////////////////////////
// Overview of operation
// [R1] A read/write start block register keeps a 9-bit block index, reset 0.
// [R2] Software loads the start block before any lock or unlock command.
// [R3] The end block location is reserved and reads zero.
// [R4] Software sets the block select before reading protection status.
// [R5] Status bits 2, 1, 0 are one-hot unlocked, locked and tight-locked.
// [R6] After reset the protection status reads 0002h, meaning locked.
// [R7] Each area is SEC-DED decoded: single corrected, double detected.
// [R8] Main and spare areas are checked on every load and on boot load.
// [R9] Class codes are 00 none, 01 single, 10 double, 11 never produced.
// [R10] The class register holds four 2-bit codes in bits 7:0.
// [R11] Main results give the word position of 256 and the line of 16.
// [R12] Position fields are rewritten on each load and each boot load.
// [R13] Spare results hold a word selector in bits 5:4, 00 or 01 only.
// [R14] Spare results also give the failing line of 16.
// [R15] Class and result registers read zero after reset.
// [R16] A failed load leaves code 10, a reset-aborted load leaves 00.
// [R17] Reserved bits read zero and writes to them have no effect.
module eps_status_regs #(
  parameter int BLK_W = `EPS_BLK_W,
  parameter int NUM_BLK = `EPS_NUM_BLK
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Lock engine
  input wire logic [BLK_W-1:0] flash_block_select,
  input wire logic lock_cmd,
  input wire logic unlock_cmd,
  input wire logic lock_tight_cmd,
  output logic [BLK_W-1:0] first_block_index,
  // Load engine: syndromes main a, spare a, main b, spare b
  input wire logic load_done,
  input wire logic boot_done,
  input wire logic load_fail,
  input wire logic load_abort,
  input wire logic [`EPS_SYN_W-1:0] syn_main_a,
  input wire logic [`EPS_SYN_W-1:0] syn_main_b,
  input wire logic [5:0] syn_spare_a,
  input wire logic [5:0] syn_spare_b,
  input wire logic [3:0] area_parity,
  // Interrupt
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  logic [15:0] idx;
  logic setup_ph;
  logic access_ph;
  logic wr_en;
  logic hit;
  logic [31:0] rd_mux;
  assign idx = paddr[17:2];
  assign setup_ph = psel && !penable;
  assign access_ph = psel && penable;
  assign pready = 1'b1;
  assign wr_en = access_ph && pwrite && hit && ce;
  always_comb begin
    case (idx)
      `EPS_IDX_START_BLK, `EPS_IDX_END_BLK, `EPS_IDX_PROT_STAT,
      `EPS_IDX_ECC_CLASS, `EPS_IDX_MAIN_A, `EPS_IDX_SPARE_A,
      `EPS_IDX_MAIN_B, `EPS_IDX_SPARE_B, `EPS_IDX_IRQ_STAT,
      `EPS_IDX_IRQ_MASK: hit = (paddr[1:0] == 2'h0);
      default: hit = 1'b0;
    endcase
  end
  assign pslverr = access_ph && !hit;

  ////////////////////////////////////////////////////////////////////////////
  // Start block register
  logic [BLK_W-1:0] start_blk_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      start_blk_q <= `EPS_RST_START_BLK;
    end else if (wr_en && idx == `EPS_IDX_START_BLK) begin
      start_blk_q <= pwdata[BLK_W-1:0]; // R1 R17
    end
  end
  assign first_block_index = start_blk_q;

  ////////////////////////////////////////////////////////////////////////////
  // Per-block lock state
  // Commands act on the start block, so it must be loaded first (R2).
  // Reset walks the table one entry a cycle; a full-width clear would not
  // map onto a RAM. Until the walk ends every block reads locked anyway.
  eps_pkg::eps_lock_t lock_mem [NUM_BLK];
  logic [BLK_W:0] init_q;
  logic init_busy;
  eps_pkg::eps_lock_t sel_state;
  eps_pkg::eps_lock_t tgt_state;
  assign init_busy = !init_q[BLK_W];
  assign tgt_state = lock_mem[start_blk_q];
  always_ff @(posedge clk) begin
    if (rst) begin
      init_q <= '0;
    end else if (ce && init_busy) begin
      init_q <= init_q + 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (ce) begin
      if (init_busy) begin
        lock_mem[init_q[BLK_W-1:0]] <= eps_pkg::EPS_LOCKED;
      end else if (tgt_state != eps_pkg::EPS_TIGHT) begin
        // A tight-locked block stays so until reset
        if (lock_tight_cmd) begin
          lock_mem[start_blk_q] <= eps_pkg::EPS_TIGHT;
        end else if (lock_cmd) begin
          lock_mem[start_blk_q] <= eps_pkg::EPS_LOCKED;
        end else if (unlock_cmd) begin
          lock_mem[start_blk_q] <= eps_pkg::EPS_UNLOCKED;
        end
      end
    end
  end
  // Status follows the selected block once the init walk ends, locked before (R4)
  assign sel_state = init_busy ? eps_pkg::EPS_LOCKED :
                     lock_mem[flash_block_select];
  logic [2:0] prot_stat;
  always_comb begin
    case (sel_state)
      eps_pkg::EPS_UNLOCKED: prot_stat = 3'h4; // R5
      eps_pkg::EPS_TIGHT: prot_stat = 3'h1; // R5
      default: prot_stat = `EPS_RST_PROT_STAT; // R5 R6
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // SEC-DED decode per area: 0 main a, 1 spare a, 2 main b, 3 spare b
  logic [`EPS_SYN_W-1:0] syn [4];
  eps_pkg::eps_class_t cls_d [4];
  logic [3:0] single_hit;
  logic [3:0] double_hit;
  logic ecc_upd;
  assign syn[0] = syn_main_a;
  assign syn[1] = {6'h00, syn_spare_a};
  assign syn[2] = syn_main_b;
  assign syn[3] = {6'h00, syn_spare_b};
  assign ecc_upd = ce && (load_done || boot_done); // R8 R12
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_area
      logic zero_syn;
      logic bad_sel;
      assign zero_syn = (syn[g] == '0);
      // Spare selector codes 10 and 11 cannot name a word
      assign bad_sel = (g % 2 == 1) && syn[g][5];
      always_comb begin
        if (zero_syn && !area_parity[g]) begin
          cls_d[g] = `EPS_CLS_NONE; // R7 R9
        end else if (area_parity[g] && !bad_sel) begin
          cls_d[g] = `EPS_CLS_SINGLE; // R7 R9
        end else begin
          cls_d[g] = `EPS_CLS_DOUBLE; // R7 R9
        end
      end
      assign single_hit[g] = (cls_d[g] == `EPS_CLS_SINGLE);
      assign double_hit[g] = (cls_d[g] == `EPS_CLS_DOUBLE);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Class register
  logic [7:0] cls_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      cls_q <= '0; // R15
    end else if (ce && load_abort) begin
      cls_q <= {4{`EPS_CLS_NONE}}; // R16
    end else if (ce && load_fail) begin
      cls_q <= {4{`EPS_CLS_DOUBLE}}; // R16
    end else if (ecc_upd) begin
      cls_q <= {cls_d[2], cls_d[3], cls_d[0], cls_d[1]}; // R8 R10
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Position registers
  // On each load or boot load, positions are kept only for a correctable error; otherwise zero.
  logic [11:0] main_a_q;
  logic [11:0] main_b_q;
  logic [5:0] spare_a_q;
  logic [5:0] spare_b_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      main_a_q <= '0; // R15
      main_b_q <= '0; // R15
      spare_a_q <= '0; // R15
      spare_b_q <= '0; // R15
    end else if (ecc_upd) begin
      main_a_q <= single_hit[0] ? syn_main_a : 12'h000; // R11 R12
      main_b_q <= single_hit[2] ? syn_main_b : 12'h000; // R11 R12
      spare_a_q <= single_hit[1] ? syn_spare_a : 6'h00; // R13 R14
      spare_b_q <= single_hit[3] ? syn_spare_b : 6'h00; // R13 R14
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status and mask
  logic [`EPS_IRQ_W-1:0] ev;
  logic [`EPS_IRQ_W-1:0] irq_stat_q;
  logic [`EPS_IRQ_W-1:0] irq_mask_q;
  logic [`EPS_IRQ_W-1:0] w1c;
  assign ev[`EPS_IRQ_CORR] = ecc_upd && |single_hit;
  assign ev[`EPS_IRQ_UNCORR] = ce && !load_abort &&
    (load_fail || (ecc_upd && |double_hit));
  assign ev[`EPS_IRQ_UPDATE] = ecc_upd || (ce && (load_fail || load_abort));
  assign w1c = (wr_en && idx == `EPS_IDX_IRQ_STAT) ?
               pwdata[`EPS_IRQ_W-1:0] : '0;
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_stat_q <= '0;
    end else if (ce) begin
      // A new event wins over a clear in the same cycle
      irq_stat_q <= (irq_stat_q & ~w1c) | ev;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_mask_q <= '0;
    end else if (wr_en && idx == `EPS_IDX_IRQ_MASK) begin
      irq_mask_q <= pwdata[`EPS_IRQ_W-1:0];
    end
  end
  assign irq = |(irq_stat_q & irq_mask_q);

  ////////////////////////////////////////////////////////////////////////////
  // Read data, captured in the setup phase so it comes from a flop
  always_comb begin
    rd_mux = '0; // R3 R17
    case (idx)
      `EPS_IDX_START_BLK: rd_mux[BLK_W-1:0] = start_blk_q;
      `EPS_IDX_PROT_STAT: rd_mux[2:0] = prot_stat;
      `EPS_IDX_ECC_CLASS: rd_mux[7:0] = cls_q; // R10
      `EPS_IDX_MAIN_A: rd_mux[11:0] = main_a_q;
      `EPS_IDX_SPARE_A: rd_mux[5:0] = spare_a_q;
      `EPS_IDX_MAIN_B: rd_mux[11:0] = main_b_q;
      `EPS_IDX_SPARE_B: rd_mux[5:0] = spare_b_q;
      `EPS_IDX_IRQ_STAT: rd_mux[`EPS_IRQ_W-1:0] = irq_stat_q;
      `EPS_IDX_IRQ_MASK: rd_mux[`EPS_IRQ_W-1:0] = irq_mask_q;
      default: rd_mux = '0;
    endcase
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata <= '0;
    end else if (ce && setup_ph) begin
      prdata <= (hit && !pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_start_write: assert property ( // R1
    wr_en && idx == `EPS_IDX_START_BLK |=>
      first_block_index == $past(pwdata[BLK_W-1:0]))
    else $error("start block write not kept");
  chk_prot_onehot: assert property ($onehot(prot_stat)) // R5
    else $error("protection status not one-hot");
  chk_prot_reset: assert property ( // R6
    $fell(rst) |-> prot_stat == `EPS_RST_PROT_STAT)
    else $error("protection status not locked after reset");
  chk_class_legal: assert property ( // R9
    cls_q[1:0] != 2'h3 && cls_q[3:2] != 2'h3 &&
    cls_q[5:4] != 2'h3 && cls_q[7:6] != 2'h3)
    else $error("reserved class code seen");
  chk_class_fail: assert property ( // R16
    ce && load_fail && !load_abort |=> cls_q == 8'hAA)
    else $error("failed load did not leave 10 codes");
  chk_class_abort: assert property ( // R16
    ce && load_abort |=> cls_q == 8'h00)
    else $error("aborted load did not leave 00 codes");
  chk_class_update: assert property ( // R8
    ecc_upd && !load_fail && !load_abort |=>
      cls_q[3:2] == $past(cls_d[0]) && cls_q[7:6] == $past(cls_d[2]))
    else $error("class not refreshed by load");
  chk_ecc_reset: assert property ( // R15
    $fell(rst) |-> cls_q == 8'h00 && main_a_q == 12'h000 &&
      spare_b_q == 6'h00)
    else $error("ecc registers not zero after reset");
  chk_spare_sel: assert property (!spare_a_q[5] && !spare_b_q[5]) // R13
    else $error("reserved spare selector stored");
  chk_rsvd_zero: assert property ( // R17
    access_ph && !pwrite && idx == `EPS_IDX_ECC_CLASS |->
      prdata[31:8] == 24'h000000)
    else $error("reserved read bits not zero");
  chk_end_rsvd: assert property ( // R3
    access_ph && !pwrite && idx == `EPS_IDX_END_BLK |->
      prdata == 32'h0000_0000)
    else $error("reserved end block location not zero");
  chk_rd_capture: assert property ( // R17
    ce && setup_ph && hit && !pwrite |=> prdata == $past(rd_mux))
    else $error("read data not captured in setup");

  ////////////////////////////////////////////////////////////////////////////
  // Lock table checks; a start block rewrite moves the target, so skip it
  chk_unlock_cmd: assert property ( // R5
    ce && !init_busy && unlock_cmd && !lock_cmd && !lock_tight_cmd &&
      tgt_state != eps_pkg::EPS_TIGHT &&
      !(wr_en && idx == `EPS_IDX_START_BLK) |=>
      tgt_state == eps_pkg::EPS_UNLOCKED)
    else $error("unlock command not applied");
  chk_lock_cmd: assert property ( // R5
    ce && !init_busy && lock_cmd && !lock_tight_cmd &&
      tgt_state != eps_pkg::EPS_TIGHT &&
      !(wr_en && idx == `EPS_IDX_START_BLK) |=>
      tgt_state == eps_pkg::EPS_LOCKED)
    else $error("lock command not applied");
  chk_tight_cmd: assert property ( // R5
    ce && !init_busy && lock_tight_cmd &&
      !(wr_en && idx == `EPS_IDX_START_BLK) |=>
      tgt_state == eps_pkg::EPS_TIGHT)
    else $error("tight lock command not applied");
  chk_tight_kept: assert property ( // R5
    !init_busy && tgt_state == eps_pkg::EPS_TIGHT &&
      !(wr_en && idx == `EPS_IDX_START_BLK) |=>
      tgt_state == eps_pkg::EPS_TIGHT)
    else $error("tight-locked block changed");

  ////////////////////////////////////////////////////////////////////////////
  // Result position and spare class checks
  chk_main_a_pos: assert property ( // R11
    ecc_upd && single_hit[0] |=> main_a_q == $past(syn_main_a))
    else $error("main a position not stored");
  chk_main_b_pos: assert property ( // R11
    ecc_upd && single_hit[2] |=> main_b_q == $past(syn_main_b))
    else $error("main b position not stored");
  chk_spare_a_pos: assert property ( // R14
    ecc_upd && single_hit[1] |=> spare_a_q == $past(syn_spare_a))
    else $error("spare a position not stored");
  chk_pos_clear: assert property ( // R12
    ecc_upd && !single_hit[2] |=> main_b_q == 12'h000)
    else $error("stale main b position kept");
  chk_pos_hold: assert property ( // R16
    ce && load_fail && !ecc_upd |=> $stable(main_a_q) &&
      $stable(spare_b_q))
    else $error("failed load changed positions");
  chk_class_spare: assert property ( // R10
    ecc_upd && !load_fail && !load_abort |=>
      cls_q[1:0] == $past(cls_d[1]) && cls_q[5:4] == $past(cls_d[3]))
    else $error("spare class not refreshed by load");

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt and enable checks
  chk_irq_set: assert property (ev[`EPS_IRQ_CORR] |=>
    irq_stat_q[`EPS_IRQ_CORR])
    else $error("event did not set status");
  chk_irq_sticky: assert property (irq_stat_q[`EPS_IRQ_CORR] &&
    !w1c[`EPS_IRQ_CORR] |=> irq_stat_q[`EPS_IRQ_CORR])
    else $error("status bit lost without clear");
  chk_ce_freeze: assert property (!ce |=> $stable(start_blk_q) &&
    $stable(cls_q) && $stable(prdata) && $stable(irq_stat_q))
    else $error("state moved while enable low");

  cov_boot: cover property (ce && boot_done ##1 cls_q != 8'h00);
  cov_corrected: cover property (ecc_upd ##1 cls_q[3:2] == 2'h1);
  cov_tight: cover property (lock_tight_cmd ##1 sel_state ==
    eps_pkg::EPS_TIGHT);
  cov_irq_race: cover property (|(w1c & ev));
  cov_fail: cover property (ce && load_fail ##1 irq);

endmodule // eps_status_regs
`default_nettype wire

// ### pkg/eps_params.svh
// Offsets, field positions, reset values and counts of the status group
`ifndef EPS_PARAMS_SVH
`define EPS_PARAMS_SVH

// Register indices; byte address is four times the index
`define EPS_IDX_START_BLK 16'hF24C
`define EPS_IDX_END_BLK 16'hF24D
`define EPS_IDX_PROT_STAT 16'hF24E
`define EPS_IDX_ECC_CLASS 16'hFF00
`define EPS_IDX_MAIN_A 16'hFF01
`define EPS_IDX_SPARE_A 16'hFF02
`define EPS_IDX_MAIN_B 16'hFF03
`define EPS_IDX_SPARE_B 16'hFF04
`define EPS_IDX_IRQ_STAT 16'hFF10
`define EPS_IDX_IRQ_MASK 16'hFF11

// Reset values
`define EPS_RST_START_BLK 9'h000
`define EPS_RST_PROT_STAT 3'h2
`define EPS_RST_ECC 2'h0

// Field layout
`define EPS_BLK_W 9
`define EPS_NUM_BLK 512
`define EPS_WORD_W 8
`define EPS_IO_W 4
`define EPS_SEL_W 2
`define EPS_SYN_W 12
`define EPS_BIT_UNLOCKED 2
`define EPS_BIT_LOCKED 1
`define EPS_BIT_TIGHT 0

// Error class codes
`define EPS_CLS_NONE 2'h0
`define EPS_CLS_SINGLE 2'h1
`define EPS_CLS_DOUBLE 2'h2

// Interrupt event bits
`define EPS_IRQ_W 3
`define EPS_IRQ_CORR 0
`define EPS_IRQ_UNCORR 1
`define EPS_IRQ_UPDATE 2

`endif

// ### pkg/eps_pkg.sv
// Types shared by the ECC and block protection status group
package eps_pkg;
  typedef logic [1:0] eps_class_t;
  typedef enum logic [1:0] {
    EPS_LOCKED,
    EPS_UNLOCKED,
    EPS_TIGHT
  } eps_lock_t;
endpackage

// ### dv/eps_load_model.sv
// Load engine model that reports load outcomes to the status group
`timescale 1ns/100ps
`default_nettype none
`include "eps_params.svh"
//////////////////////////////////////////////////////////////////////////////
module eps_load_model (
  // Clock
  input wire logic clk,
  // Load outcome
  output logic load_done,
  output logic boot_done,
  output logic load_fail,
  output logic load_abort,
  output logic [`EPS_SYN_W-1:0] syn_main_a,
  output logic [`EPS_SYN_W-1:0] syn_main_b,
  output logic [5:0] syn_spare_a,
  output logic [5:0] syn_spare_b,
  output logic [3:0] area_parity
);
  initial begin
    {load_done, boot_done, load_fail, load_abort} = 4'h0;
    {syn_main_a, syn_main_b, syn_spare_a, syn_spare_b} = 36'h0;
    area_parity = 4'h0;
  end

  // Kind 0 load, 1 boot load, 2 failed load, 3 reset-aborted load
  task automatic fire(input int kind, input logic [11:0] ma, input logic
      [11:0] mb, input logic [5:0] sa, input logic [5:0] sb, input logic
      [3:0] par);
    @(posedge clk);
    load_done <= (kind == 0);
    boot_done <= (kind == 1);
    load_fail <= (kind == 2);
    load_abort <= (kind == 3);
    syn_main_a <= ma;
    syn_main_b <= mb;
    syn_spare_a <= sa;
    syn_spare_b <= sb;
    area_parity <= par;
    @(posedge clk);
    {load_done, boot_done, load_fail, load_abort} <= 4'h0;
    // Syndromes mean nothing past the pulse, so show stale garbage
    {syn_main_a, syn_main_b} <= ~{ma, mb};
    {syn_spare_a, syn_spare_b, area_parity} <= ~{sa, sb, par};
  endtask
endmodule // eps_load_model
`default_nettype wire

// ### dv/eps_status_regs_tb.sv
// Self-checking bench for the ECC and block protection status group
`timescale 1ns/100ps
`default_nettype none
`include "eps_params.svh"
//////////////////////////////////////////////////////////////////////////////
module eps_status_regs_tb;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [17:0] paddr = 18'h0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, irq, load_done, boot_done, load_fail, load_abort;
  logic [8:0] flash_block_select = 9'h0, first_block_index;
  logic lock_cmd = 1'b0, unlock_cmd = 1'b0, lock_tight_cmd = 1'b0;
  logic [11:0] syn_main_a, syn_main_b;
  logic [5:0] syn_spare_a, syn_spare_b;
  logic [3:0] area_parity;
  logic [31:0] rdv;
  logic errv;
  logic ce = 1'b1;
  int fail_count = 0;
  int n_tests = 0;

  eps_status_regs dut (.clk(clk), .rst(rst), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flash_block_select(flash_block_select), .lock_cmd(lock_cmd),
    .unlock_cmd(unlock_cmd), .lock_tight_cmd(lock_tight_cmd),
    .first_block_index(first_block_index), .load_done(load_done),
    .boot_done(boot_done), .load_fail(load_fail), .load_abort(load_abort),
    .syn_main_a(syn_main_a), .syn_main_b(syn_main_b),
    .syn_spare_a(syn_spare_a), .syn_spare_b(syn_spare_b),
    .area_parity(area_parity), .irq(irq));
  eps_load_model eng (.clk(clk), .load_done(load_done),
    .boot_done(boot_done), .load_fail(load_fail), .load_abort(load_abort),
    .syn_main_a(syn_main_a), .syn_main_b(syn_main_b),
    .syn_spare_a(syn_spare_a), .syn_spare_b(syn_spare_b),
    .area_parity(area_parity));

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Byte address is four times the register index
  task automatic apb(logic w, logic [15:0] idx, logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(string nm, logic [15:0] idx, logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(nm, exp, rdv);
  endtask

  task automatic cmd(int k);
    @(posedge clk);
    {unlock_cmd, lock_cmd, lock_tight_cmd} <= 3'h4 >> k;
    @(posedge clk);
    {unlock_cmd, lock_cmd, lock_tight_cmd} <= 3'h0;
  endtask

  task automatic t_reset();
    logic [15:0] idx [8];
    idx = '{`EPS_IDX_START_BLK, `EPS_IDX_END_BLK, `EPS_IDX_PROT_STAT,
      `EPS_IDX_ECC_CLASS, `EPS_IDX_MAIN_A, `EPS_IDX_SPARE_A,
      `EPS_IDX_MAIN_B, `EPS_IDX_SPARE_B};
    for (int i = 0; i < 8; i++) begin
      rd("reset value", idx[i], (i == 2) ? 32'h0000_0002 : 32'h0);
    end
    chk("irq", 32'h0, {31'h0, irq});
    $display("t_reset done");
  endtask

  task automatic t_regs();
    apb(1'b1, `EPS_IDX_START_BLK, 32'hFFFF_FFFF);
    @(negedge clk);
    chk("block index", 32'h0000_01FF, {23'h0, first_block_index});
    rd("start block", `EPS_IDX_START_BLK, 32'h0000_01FF);
    @(posedge clk);
    ce <= 1'b0;
    apb(1'b1, `EPS_IDX_START_BLK, 32'h0000_0000);
    ce <= 1'b1;
    rd("start frozen", `EPS_IDX_START_BLK, 32'h0000_01FF);
    apb(1'b1, `EPS_IDX_END_BLK, 32'hFFFF_FFFF);
    rd("end block", `EPS_IDX_END_BLK, 32'h0);
    apb(1'b1, `EPS_IDX_ECC_CLASS, 32'hFFFF_FFFF);
    rd("class ro", `EPS_IDX_ECC_CLASS, 32'h0);
    apb(1'b0, 16'h0000, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, errv});
    $display("t_regs done");
  endtask

  task automatic t_lock();
    // Start block first, then select the same block before reading
    apb(1'b1, `EPS_IDX_START_BLK, 32'h0000_0005);
    @(posedge clk);
    flash_block_select <= 9'h005;
    cmd(0);
    rd("unlocked", `EPS_IDX_PROT_STAT, 32'h0000_0004);
    cmd(1);
    rd("locked", `EPS_IDX_PROT_STAT, 32'h0000_0002);
    cmd(2);
    rd("tight", `EPS_IDX_PROT_STAT, 32'h0000_0001);
    cmd(0);
    rd("tight kept", `EPS_IDX_PROT_STAT, 32'h0000_0001);
    @(posedge clk);
    flash_block_select <= 9'h006;
    rd("other block", `EPS_IDX_PROT_STAT, 32'h0000_0002);
    $display("t_lock done");
  endtask

  task automatic t_ecc();
    eng.fire(0, 12'h000, 12'hFFF, 6'h1A, 6'h05, 4'b0110);
    rd("class mix", `EPS_IDX_ECC_CLASS, 32'h0000_0061);
    rd("main a", `EPS_IDX_MAIN_A, 32'h0);
    rd("spare a", `EPS_IDX_SPARE_A, 32'h0000_001A);
    rd("main b", `EPS_IDX_MAIN_B, 32'h0000_0FFF);
    rd("spare b", `EPS_IDX_SPARE_B, 32'h0);
    eng.fire(1, 12'h123, 12'h000, 6'h00, 6'h00, 4'b0001);
    rd("boot class", `EPS_IDX_ECC_CLASS, 32'h0000_0004);
    rd("boot main a", `EPS_IDX_MAIN_A, 32'h0000_0123);
    rd("boot main b", `EPS_IDX_MAIN_B, 32'h0);
    eng.fire(2, 12'h0, 12'h0, 6'h0, 6'h0, 4'h0);
    rd("fail class", `EPS_IDX_ECC_CLASS, 32'h0000_00AA);
    eng.fire(3, 12'h0, 12'h0, 6'h0, 6'h0, 4'h0);
    rd("abort class", `EPS_IDX_ECC_CLASS, 32'h0);
    $display("t_ecc done");
  endtask

  task automatic t_irq();
    apb(1'b1, `EPS_IDX_IRQ_MASK, 32'h0);
    apb(1'b1, `EPS_IDX_IRQ_STAT, 32'h0000_0007);
    rd("irq clear", `EPS_IDX_IRQ_STAT, 32'h0);
    eng.fire(0, 12'h045, 12'h0, 6'h0, 6'h0, 4'b0001);
    rd("irq status", `EPS_IDX_IRQ_STAT, 32'h0000_0005);
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(1'b1, `EPS_IDX_IRQ_MASK, 32'h0000_0001);
    @(negedge clk);
    chk("irq on", 32'h1, {31'h0, irq});
    apb(1'b1, `EPS_IDX_IRQ_STAT, 32'h0000_0007);
    @(negedge clk);
    chk("irq off", 32'h0, {31'h0, irq});
    $display("t_irq done");
  endtask

  task automatic end_sim();
    $display("Checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    #100000;
    fail_count++;
    end_sim();
  end

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_regs();
    t_ecc();
    // Lock commands are ignored until the table init walk has finished
    repeat (520) @(posedge clk);
    t_lock();
    t_irq();
    end_sim();
  end
endmodule // eps_status_regs_tb
`default_nettype wire
